// file: rtl/queue_element_address.sv
// Registered physical address of one queue element
`timescale 1ns/1ns
module queue_element_address
  import tx_queue_pointer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire tx_queue_pointer_pkg::address_t transmit_queue_base,
  input wire tx_queue_pointer_pkg::pointer_t pointer,
  output tx_queue_pointer_pkg::address_t element_address
);

  typedef struct packed
  {
    address_t address;
  } state_s;

  state_s state;
  state_s next_state;

  // ----------------------------------------------------------------
  // Address former
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.address = transmit_queue_base + {ADDRESS_HIGH_PAD, pointer, ELEMENT_PAD};
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{address: ADDRESS_RESET};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign element_address = state.address;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Gated on reset_n: the edge that releases reset still loads the reset value
  property p_element_address_sum;
    @(posedge clock) disable iff (!reset_n)
    reset_n |=> element_address == $past(transmit_queue_base) + {ADDRESS_HIGH_PAD, $past(pointer), ELEMENT_PAD};
  endproperty
  a_element_address_sum: assert property (p_element_address_sum)
    else $error("element address is not base plus pointer times four");

endmodule

// file: rtl/tx_descriptor_ref_queue_pointers.sv
// Transmit descriptor reference free and ready queue pointer registers
// Notes on behaviour
// - Free-queue write pointer holds element address bits 17 to 2.
// - Element address is base plus pointer shifted left by two.
// - Free-queue read pointer holds element address bits 17 to 2.
// - Free-queue end register holds element address bits 17 to 2.
// - Ready-queue start register holds element address bits 17 to 2.
// - Ready-queue write pointer holds element address bits 17 to 2.
// - A write replaces the whole register whatever byte enables are active.
// - With all four byte enables off, no read or write happens.
`timescale 1ns/1ns
module tx_descriptor_ref_queue_pointers
  import tx_queue_pointer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic access_valid,
  input wire logic access_write,
  input wire tx_queue_pointer_pkg::offset_t access_address,
  input wire logic [3:0] bus_byte_enables_n,
  input wire logic [31:0] write_data,
  output logic [31:0] read_data,
  output logic access_done,
  input wire tx_queue_pointer_pkg::address_t transmit_queue_base,
  input wire tx_queue_pointer_pkg::pointer_t free_queue_start_address,
  input wire tx_queue_pointer_pkg::pointer_t ready_queue_end_address,
  input wire logic free_read_advance,
  input wire logic ready_write_advance,
  output tx_queue_pointer_pkg::address_t free_write_element_address,
  output tx_queue_pointer_pkg::address_t free_read_element_address,
  output tx_queue_pointer_pkg::address_t free_end_element_address,
  output tx_queue_pointer_pkg::address_t ready_start_element_address,
  output tx_queue_pointer_pkg::address_t ready_write_element_address,
  output logic free_queue_available,
  output logic spacing_violation
);
  import tx_queue_pointer_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    pointer_t [POINTER_COUNT-1:0] pointers;
    logic [31:0] read_data;
    logic access_done;
    logic [2:0] since_guarded_write;
    logic free_queue_available;
    logic spacing_violation;
  } state_s;

  state_s state;
  state_s next_state;

  logic byte_lanes_active;
  logic host_write;
  index_t slot;
  logic guarded_slot;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic index_t decode_slot(input offset_t address);
    index_t result;
    result = SLOT_NONE;
    if (address == FREE_QUEUE_WRITE_POINTER_OFFSET)
      result = SLOT_FREE_WRITE;
    else if (address == FREE_QUEUE_READ_POINTER_OFFSET)
      result = SLOT_FREE_READ;
    else if (address == FREE_QUEUE_END_ADDRESS_OFFSET)
      result = SLOT_FREE_END;
    else if (address == READY_QUEUE_START_ADDRESS_OFFSET)
      result = SLOT_READY_START;
    else if (address == READY_QUEUE_WRITE_POINTER_OFFSET)
      result = SLOT_READY_WRITE;
    return result;
  endfunction

  // Step one element along a ring; the end element itself is used before wrapping
  function automatic pointer_t ring_next(input pointer_t current, input pointer_t start, input pointer_t last);
    pointer_t result;
    if (current == last)
      result = start;
    else
      result = current + 16'h0001;
    return result;
  endfunction

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb
  begin
    byte_lanes_active = bus_byte_enables_n != BYTE_ENABLES_NONE_N;
    slot = decode_slot(access_address);
    host_write = access_valid && access_write && byte_lanes_active && slot != SLOT_NONE;
    guarded_slot = slot == SLOT_FREE_WRITE || slot == SLOT_FREE_READ || slot == SLOT_READY_WRITE;
  end

  always_comb
  begin
    next_state = state;
    next_state.access_done = 1'b0;
    next_state.spacing_violation = 1'b0;

    // Hardware advance first so a host write in the same cycle overrides it
    if (free_read_advance)
    begin
      next_state.pointers[SLOT_FREE_READ] = ring_next(state.pointers[SLOT_FREE_READ],
        free_queue_start_address, state.pointers[SLOT_FREE_END]);
    end
    if (ready_write_advance)
    begin
      next_state.pointers[SLOT_READY_WRITE] = ring_next(state.pointers[SLOT_READY_WRITE],
        state.pointers[SLOT_READY_START], ready_queue_end_address);
    end

    if (access_valid)
    begin
      next_state.access_done = 1'b1;
      next_state.read_data = 32'h0000_0000;
      if (byte_lanes_active && slot != SLOT_NONE)
      begin
        if (access_write)
        begin
          // Whole field loads, byte enables only gate the access as a whole
          next_state.pointers[slot] = write_data[POINTER_WIDTH-1:0];
        end
        else
        begin
          next_state.read_data = {UNUSED_READ_BITS, state.pointers[slot]};
        end
      end
    end

    // Host is meant to space these writes; flag it rather than stall
    if (host_write && guarded_slot)
    begin
      next_state.since_guarded_write = 3'h1;
      if (state.since_guarded_write != 3'h0 && state.since_guarded_write < WRITE_SPACING_CYCLES)
      begin
        next_state.spacing_violation = 1'b1;
      end
    end
    else if (state.since_guarded_write != 3'h0 && state.since_guarded_write < WRITE_SPACING_CYCLES)
    begin
      next_state.since_guarded_write = state.since_guarded_write + 3'h1;
    end
    else
    begin
      next_state.since_guarded_write = 3'h0;
    end

    next_state.free_queue_available = next_state.pointers[SLOT_FREE_READ] != next_state.pointers[SLOT_FREE_WRITE];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{pointers: {POINTER_COUNT{POINTER_RESET}},
                 read_data: 32'h0000_0000,
                 access_done: 1'b0,
                 since_guarded_write: 3'h0,
                 free_queue_available: 1'b0,
                 spacing_violation: 1'b0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign read_data = state.read_data;
  assign access_done = state.access_done;
  assign free_queue_available = state.free_queue_available;
  assign spacing_violation = state.spacing_violation;

  // ----------------------------------------------------------------
  // Physical element addresses
  // ----------------------------------------------------------------
  address_t [POINTER_COUNT-1:0] element_addresses;

  for (genvar i = 0; i < POINTER_COUNT; i++)
  begin : g_element
    queue_element_address queue_element_address_inst (
      .clock(clock),
      .reset_n(reset_n),
      .transmit_queue_base(transmit_queue_base),
      .pointer(state.pointers[i]),
      .element_address(element_addresses[i])
    );
  end

  assign free_write_element_address = element_addresses[SLOT_FREE_WRITE];
  assign free_read_element_address = element_addresses[SLOT_FREE_READ];
  assign free_end_element_address = element_addresses[SLOT_FREE_END];
  assign ready_start_element_address = element_addresses[SLOT_READY_START];
  assign ready_write_element_address = element_addresses[SLOT_READY_WRITE];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic write_lanes_on;
  assign write_lanes_on = access_valid && access_write && byte_lanes_active;

  property p_free_write_load;
    write_lanes_on && access_address == FREE_QUEUE_WRITE_POINTER_OFFSET
      |=> state.pointers[SLOT_FREE_WRITE] == $past(write_data[15:0]) ##1
          free_write_element_address == transmit_queue_base
            + {ADDRESS_HIGH_PAD, $past(write_data[15:0], 2), ELEMENT_PAD}
          || $past(transmit_queue_base) != transmit_queue_base || $past(access_valid);
  endproperty
  a_free_write_load: assert property (p_free_write_load) else $error("free write pointer did not load");

  property p_free_read_load;
    write_lanes_on && access_address == FREE_QUEUE_READ_POINTER_OFFSET
      |=> state.pointers[SLOT_FREE_READ] == $past(write_data[15:0]);
  endproperty
  a_free_read_load: assert property (p_free_read_load) else $error("free read pointer did not load");

  property p_free_end_load;
    write_lanes_on && access_address == FREE_QUEUE_END_ADDRESS_OFFSET
      |=> state.pointers[SLOT_FREE_END] == $past(write_data[15:0]);
  endproperty
  a_free_end_load: assert property (p_free_end_load) else $error("free end register did not load");

  property p_ready_start_load;
    write_lanes_on && access_address == READY_QUEUE_START_ADDRESS_OFFSET
      |=> state.pointers[SLOT_READY_START] == $past(write_data[15:0]);
  endproperty
  a_ready_start_load: assert property (p_ready_start_load) else $error("ready start register did not load");

  property p_ready_write_readback;
    write_lanes_on && access_address == READY_QUEUE_WRITE_POINTER_OFFSET ##1
      access_valid && !access_write && byte_lanes_active && access_address == READY_QUEUE_WRITE_POINTER_OFFSET
      && !ready_write_advance && !$past(ready_write_advance)
      |=> read_data == {UNUSED_READ_BITS, $past(write_data[15:0], 2)} && access_done;
  endproperty
  a_ready_write_readback: assert property (p_ready_write_readback)
    else $error("ready write pointer read back wrong");

  property p_partial_enables_full_write;
    write_lanes_on && bus_byte_enables_n != 4'h0 && slot != SLOT_NONE
      |=> state.pointers[$past(slot)] == $past(write_data[15:0]);
  endproperty
  a_partial_enables_full_write: assert property (p_partial_enables_full_write)
    else $error("partial byte enables changed only part");

  property p_no_lanes_no_access;
    access_valid && bus_byte_enables_n == BYTE_ENABLES_NONE_N && !free_read_advance && !ready_write_advance
      |=> state.pointers == $past(state.pointers) && read_data == 32'h0000_0000 && access_done;
  endproperty
  a_no_lanes_no_access: assert property (p_no_lanes_no_access)
    else $error("access made with all byte enables off");

  property p_free_read_wraps;
    free_read_advance && !host_write && state.pointers[SLOT_FREE_READ] == state.pointers[SLOT_FREE_END]
      |=> state.pointers[SLOT_FREE_READ] == $past(free_queue_start_address);
  endproperty
  a_free_read_wraps: assert property (p_free_read_wraps)
    else $error("free read pointer did not wrap to start");

  property p_ready_write_steps;
    ready_write_advance && !host_write && state.pointers[SLOT_READY_WRITE] != ready_queue_end_address
      |=> state.pointers[SLOT_READY_WRITE] == $past(state.pointers[SLOT_READY_WRITE]) + 16'h0001;
  endproperty
  a_ready_write_steps: assert property (p_ready_write_steps)
    else $error("ready write pointer did not step by one");

  c_host_write: cover property (write_lanes_on && slot != SLOT_NONE);
  c_host_read: cover property (access_valid && !access_write && byte_lanes_active && slot != SLOT_NONE);
  c_free_wrap: cover property (free_read_advance && state.pointers[SLOT_FREE_READ] == state.pointers[SLOT_FREE_END]);
  c_spacing_flag: cover property (spacing_violation);
  c_back_to_back: cover property (write_lanes_on ##1 access_valid && !access_write);

  // Guarded write taken at this edge
  logic guarded_write;
  assign guarded_write = host_write && guarded_slot;

  property p_close_write_flagged;
    guarded_write && ($past(guarded_write) || $past(guarded_write, 2) || $past(guarded_write, 3))
      |=> spacing_violation;
  endproperty
  a_close_write_flagged: assert property (p_close_write_flagged) else $error("close writes not flagged");

  property p_flag_has_cause;
    spacing_violation
      |-> $past(guarded_write) && ($past(guarded_write, 2) || $past(guarded_write, 3) || $past(guarded_write, 4));
  endproperty
  a_flag_has_cause: assert property (p_flag_has_cause) else $error("flag without close writes");

  property p_unused_read_zero;
    access_valid && !access_write
      |=> read_data[31:16] == UNUSED_READ_BITS && access_done;
  endproperty
  a_unused_read_zero: assert property (p_unused_read_zero) else $error("unused read bits not zero");

endmodule

// file: rtl/tx_queue_pointer_pkg.sv
// Constants and types shared by the transmit queue pointer bank
package tx_queue_pointer_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDRESS_WIDTH = 12;
  localparam int POINTER_WIDTH = 16;
  localparam int POINTER_COUNT = 5;
  localparam int ELEMENT_SHIFT = 2;

  typedef logic [ADDRESS_WIDTH-1:0] offset_t;
  typedef logic [POINTER_WIDTH-1:0] pointer_t;
  typedef logic [31:0] address_t;
  typedef logic [2:0] index_t;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam offset_t FREE_QUEUE_WRITE_POINTER_OFFSET = 12'h31c;
  localparam offset_t FREE_QUEUE_READ_POINTER_OFFSET = 12'h320;
  localparam offset_t FREE_QUEUE_END_ADDRESS_OFFSET = 12'h324;
  localparam offset_t READY_QUEUE_START_ADDRESS_OFFSET = 12'h328;
  localparam offset_t READY_QUEUE_WRITE_POINTER_OFFSET = 12'h32c;

  // ----------------------------------------------------------------
  // Slots of the pointer array
  // ----------------------------------------------------------------
  localparam index_t SLOT_FREE_WRITE = 3'h0;
  localparam index_t SLOT_FREE_READ = 3'h1;
  localparam index_t SLOT_FREE_END = 3'h2;
  localparam index_t SLOT_READY_START = 3'h3;
  localparam index_t SLOT_READY_WRITE = 3'h4;
  localparam index_t SLOT_NONE = 3'h7;

  // ----------------------------------------------------------------
  // Reset values, encodings, timing
  // ----------------------------------------------------------------
  localparam pointer_t POINTER_RESET = 16'h0000;
  localparam address_t ADDRESS_RESET = 32'h0000_0000;
  localparam logic [15:0] UNUSED_READ_BITS = 16'h0000;
  localparam logic [3:0] BYTE_ENABLES_NONE_N = 4'hf;
  localparam logic [1:0] ELEMENT_PAD = 2'h0;
  localparam logic [13:0] ADDRESS_HIGH_PAD = 14'h0000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int WRITE_SPACING_SYSTEM_CLOCKS = 4;
  localparam logic [2:0] WRITE_SPACING_CYCLES = 3'(WRITE_SPACING_SYSTEM_CLOCKS);

endpackage

// file: test/tx_descriptor_ref_queue_pointers_test.sv
// Self-checking testbench for the transmit queue pointer bank
`timescale 1ns/1ns
module tx_descriptor_ref_queue_pointers_test;
  import tx_queue_pointer_pkg::*;

  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic access_valid = 1'b0;
  logic access_write = 1'b0;
  offset_t access_address = 12'h000;
  logic [3:0] bus_byte_enables_n = 4'hf;
  logic [31:0] write_data = 32'h0000_0000;
  logic [31:0] read_data;
  logic access_done;
  // Word aligned, with a carry across bit 17 when pointers are added
  address_t transmit_queue_base = 32'h0013_fff0;
  pointer_t free_queue_start_address = 16'h0010;
  pointer_t ready_queue_end_address = 16'h0021;
  logic free_read_advance = 1'b0;
  logic ready_write_advance = 1'b0;
  address_t free_write_element_address;
  address_t free_read_element_address;
  address_t free_end_element_address;
  address_t ready_start_element_address;
  address_t ready_write_element_address;
  logic free_queue_available;
  logic spacing_violation;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seen_data;
  logic seen_spacing;
  pointer_t held [5];
  offset_t offs [5] = '{FREE_QUEUE_WRITE_POINTER_OFFSET, FREE_QUEUE_READ_POINTER_OFFSET,
    FREE_QUEUE_END_ADDRESS_OFFSET, READY_QUEUE_START_ADDRESS_OFFSET, READY_QUEUE_WRITE_POINTER_OFFSET};
  logic [3:0] lanes_n [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc};

  tx_descriptor_ref_queue_pointers tx_descriptor_ref_queue_pointers_inst (
    .clock(clock),
    .reset_n(reset_n),
    .access_valid(access_valid),
    .access_write(access_write),
    .access_address(access_address),
    .bus_byte_enables_n(bus_byte_enables_n),
    .write_data(write_data),
    .read_data(read_data),
    .access_done(access_done),
    .transmit_queue_base(transmit_queue_base),
    .free_queue_start_address(free_queue_start_address),
    .ready_queue_end_address(ready_queue_end_address),
    .free_read_advance(free_read_advance),
    .ready_write_advance(ready_write_advance),
    .free_write_element_address(free_write_element_address),
    .free_read_element_address(free_read_element_address),
    .free_end_element_address(free_end_element_address),
    .ready_start_element_address(ready_start_element_address),
    .ready_write_element_address(ready_write_element_address),
    .free_queue_available(free_queue_available),
    .spacing_violation(spacing_violation)
  );

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    n_checks++;
    if (seen !== expected)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, expected, seen);
    end
  endtask

  function automatic address_t elem(input int i);
    case (i)
      0: return free_write_element_address;
      1: return free_read_element_address;
      2: return free_end_element_address;
      3: return ready_start_element_address;
      default: return ready_write_element_address;
    endcase
  endfunction

  function automatic address_t expect_addr(input pointer_t p);
    return transmit_queue_base + {14'h0000, p, 2'h0};
  endfunction

  // One access; request held until the taking edge, answer seen just after that edge
  task automatic bus(input logic wr, input offset_t addr, input logic [3:0] be_n, input logic [31:0] data);
    @(posedge clock);
    access_valid <= 1'b1;
    access_write <= wr;
    access_address <= addr;
    bus_byte_enables_n <= be_n;
    write_data <= data;
    @(posedge clock);
    access_valid <= 1'b0;
    #1;
    check("access_done", {31'h0, access_done}, 32'h1);
    seen_data = read_data;
    seen_spacing = spacing_violation;
  endtask

  // Write followed by enough idle edges to respect the host spacing
  task automatic wr(input int i, input pointer_t v);
    bus(1'b1, offs[i], 4'h0, {16'h0000, v});
    held[i] = v;
    repeat (2) @(posedge clock);
  endtask

  task automatic step(input logic ready_side);
    @(posedge clock);
    if (ready_side)
      ready_write_advance <= 1'b1;
    else
      free_read_advance <= 1'b1;
    @(posedge clock);
    ready_write_advance <= 1'b0;
    free_read_advance <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, offs[i], 4'h0, 32'h0000_0000);
      check("reset_value", seen_data, 32'h0000_0000);
      check("reset_address", elem(i), transmit_queue_base);
    end
    check("reset_available", {31'h0, free_queue_available}, 32'h0);
    $display("test_reset done");
  endtask

  // Partial lanes still replace all sixteen bits; upper data bits are dropped
  task automatic test_write_read();
    pointer_t v;
    for (int i = 0; i < 5; i++)
    begin
      v = 16'h8421 + pointer_t'(i * 3);
      bus(1'b1, offs[i], lanes_n[i], {16'hab00, v});
      held[i] = v;
      @(posedge clock);
      #1;
      check("element_address", elem(i), expect_addr(v));
      repeat (2) @(posedge clock);
      bus(1'b0, offs[i], lanes_n[(i + 1) % 5], 32'h0000_0000);
      check("read_back", seen_data, {16'h0000, v});
    end
    $display("test_write_read done");
  endtask

  task automatic test_no_lanes();
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, offs[i], BYTE_ENABLES_NONE_N, 32'h0000_5a5a);
      repeat (3) @(posedge clock);
      bus(1'b0, offs[i], BYTE_ENABLES_NONE_N, 32'h0000_0000);
      check("no_lane_read", seen_data, 32'h0000_0000);
      bus(1'b0, offs[i], 4'h0, 32'h0000_0000);
      check("no_lane_kept", seen_data, {16'h0000, held[i]});
    end
    bus(1'b0, 12'h330, 4'h0, 32'h0000_0000);
    check("unmapped_read", seen_data, 32'h0000_0000);
    $display("test_no_lanes done");
  endtask

  // Close writes are still applied but flagged; a four edge gap is clean
  task automatic test_spacing();
    bus(1'b1, offs[0], 4'h0, 32'h0000_0101);
    check("first_write_flag", {31'h0, seen_spacing}, 32'h0);
    bus(1'b1, offs[0], 4'h0, 32'h0000_0202);
    check("close_write_flag", {31'h0, seen_spacing}, 32'h1);
    repeat (2) @(posedge clock);
    bus(1'b0, offs[0], 4'h0, 32'h0000_0000);
    check("close_write_kept", seen_data, 32'h0000_0202);
    repeat (4) @(posedge clock);
    wr(0, 16'h0303);
    bus(1'b1, offs[0], 4'h0, 32'h0000_0404);
    check("spaced_write_flag", {31'h0, seen_spacing}, 32'h0);
    $display("test_spacing done");
  endtask

  task automatic test_wrap();
    repeat (4) @(posedge clock);
    wr(2, 16'h0012);
    wr(0, 16'h0011);
    wr(1, 16'h0011);
    wr(3, 16'h0020);
    wr(4, 16'h0021);
    check("empty_free_queue", {31'h0, free_queue_available}, 32'h0);
    step(1'b0);
    check("free_read_step", free_read_element_address, expect_addr(16'h0012));
    check("free_queue_filled", {31'h0, free_queue_available}, 32'h1);
    step(1'b0);
    check("free_read_wrap", free_read_element_address, expect_addr(free_queue_start_address));
    step(1'b1);
    check("ready_write_wrap", ready_write_element_address, expect_addr(16'h0020));
    bus(1'b0, offs[4], 4'h0, 32'h0000_0000);
    check("ready_write_read", seen_data, 32'h0000_0020);
    $display("test_wrap done");
  endtask

  // Write then read on consecutive edges; the read sees the new value
  task automatic test_back_to_back();
    @(posedge clock);
    access_valid <= 1'b1;
    access_write <= 1'b1;
    access_address <= offs[4];
    bus_byte_enables_n <= 4'h3;
    write_data <= 32'h0000_0abc;
    @(posedge clock);
    access_write <= 1'b0;
    write_data <= 32'h0000_0000;
    @(posedge clock);
    access_valid <= 1'b0;
    #1;
    check("back_to_back_read", read_data, 32'h0000_0abc);
    check("back_to_back_done", {31'h0, access_done}, 32'h1);
    $display("test_back_to_back done");
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    test_reset();
    test_write_read();
    test_no_lanes();
    test_spacing();
    test_wrap();
    test_back_to_back();
    test_done();
  end

endmodule
